// *** src/adc_ctl_pkg.sv ***
/*
  shared constants for the serial converter control block and its host end.
  assumes a 25 MHz system clock on both ends and a slow serial clock.
*/
package adc_ctl_pkg;
  // ----------------------------------------
  // control word layout (12 bits, msb first)
  // ----------------------------------------
  localparam int CTL_W = 12;
  localparam int WORD_W = 16;
  localparam int RES_W = 12;
  localparam int BIT_WRITE = 11;
  localparam int BIT_SEQ_HI = 10;
  localparam int BIT_CH_HI = 7;
  localparam int BIT_CH_LO = 6;
  localparam int BIT_PWR_HI = 5;
  localparam int BIT_PWR_LO = 4;
  localparam int BIT_SEQ_LO = 3;
  localparam logic [11:0] CTL_RESET = 12'hFFF;
  // ----------------------------------------
  // serial timing, in serial clock edges
  // ----------------------------------------
  localparam logic [4:0] EDGES_CTL = 5'h0C;
  localparam logic [4:0] EDGE_TRACK = 5'h0E;
  localparam logic [4:0] EDGES_WORD = 5'h10;
  // ----------------------------------------
  // host timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 40;
  localparam int SCLK_HALF_CYC = 4;
  localparam int CONV_PERIOD_NS = 5000;
  localparam int CONV_CYC = (CONV_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int QUIET_NS = 50;
  localparam int QUIET_CYC = (QUIET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // ----------------------------------------
  // apb register map of the host
  // ----------------------------------------
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_DATA = 8'h08;
  // order follows the two power bits: 00 spare, 01 auto off, 10 full off, 11 normal
  typedef enum logic [1:0] {PWR_OFF_ALT, PWR_AUTO_OFF, PWR_FULL_OFF, PWR_NORMAL} pwr_mode_t;
endpackage

// *** src/adc_link_if.sv ***
/*
  serial link between host and converter control.
  assumes the bench resolves the data output line from its enable.
*/
`timescale 1ns/1ps
`default_nettype none
interface adc_link_if;
  logic cs_n;
  logic sclk;
  logic din;
  logic dout;
  logic dout_oe;
  modport dev (input cs_n, input sclk, input din, output dout, output dout_oe);
  modport host (output cs_n, output sclk, output din, input dout, input dout_oe);
endinterface
`default_nettype wire

// *** src/sync3.sv ***
/*
  three-stage synchroniser with agreement filter.
  assumes an asynchronous input; output changes when stages two and three agree.
*/
`timescale 1ns/1ps
`default_nettype none
module sync3 (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic async_i,
  output logic sync_o
);
  logic s1;
  logic s2;
  logic s3;
  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      s1 <= 1'b1;
      s2 <= 1'b1;
      s3 <= 1'b1;
      sync_o <= 1'b1;
    end
    else
    begin
      s1 <= async_i;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3)
        sync_o <= s3;
    end
  end
endmodule
`default_nettype wire

// *** src/adc_dev_ctl.sv ***
/*
  converter end: control register, channel sequencer, power modes, output word.
  assumes the host keeps throughput, quiet time and wake time limits.
*/
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - channel bits pick one of four inputs
// - sequence bits 1,1 start ascending scan
// - first transfer after programming converts channel 0
// - sequence bits 1,0 keep sequence, others end
// - write bit 0 leaves control unchanged
// - after final channel wrap to channel 0
// - word: two zeros, channel, 12-bit result
// - normal mode stays powered, no wake
// - cs fall starts; first 12 bits load control
// - sixteen clocks; track on 14th fall
// - host keeps 5 us between cs falls
// - host waits quiet time before cs low
// - host may idle cs high or low
// - full shutdown powers down, keeps control
// - wake from full shutdown: no output drive
// - host waits wake time after full shutdown
// - auto shutdown powers down after conversion
// - auto shutdown wakes on cs fall
// - host allows 1 us auto wake
// - early cs rise aborts, no update
// - output released on 16th falling edge
// - control bits msb first, write bit first
// - output changes on sclk falling edges
module adc_dev_ctl
  import adc_ctl_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic nrst_i,
  adc_link_if.dev link,
  input wire logic [RES_W-1:0] sample_i,
  output logic [1:0] mux_sel_o,
  output logic tracking_o,
  output logic powered_o,
  output logic [CTL_W-1:0] ctl_o,
  output logic busy_o
);
  import adc_ctl_pkg::*;

  // ----------------------------------------
  // pin sampling
  // ----------------------------------------
  logic cs_s;
  logic sclk_s;
  logic din_s;
  logic cs_d;
  logic sclk_d;
  sync3 u_cs (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .async_i(link.cs_n), .sync_o(cs_s));
  sync3 u_sck (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .async_i(link.sclk), .sync_o(sclk_s));
  sync3 u_din (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .async_i(link.din), .sync_o(din_s));

  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      cs_d <= 1'b1;
      sclk_d <= 1'b1;
    end
    else
    begin
      cs_d <= cs_s;
      sclk_d <= sclk_s;
    end
  end

  wire cs_fall = cs_d & ~cs_s;
  wire cs_rise = ~cs_d & cs_s;
  wire sclk_fall = sclk_d & ~sclk_s & ~cs_s;

  // ----------------------------------------
  // transfer state
  // ----------------------------------------
  logic [4:0] edge_cnt;
  logic [CTL_W-1:0] ctl;
  logic [CTL_W-1:0] shift_in;
  logic [WORD_W-1:0] shift_out;
  logic [1:0] conv_ch;
  logic [1:0] seq_ch;
  logic seq_on;
  logic active;
  logic drive_ok;
  pwr_mode_t pwr;

  function automatic pwr_mode_t pwr_of(input logic [CTL_W-1:0] w);
    pwr_of = pwr_mode_t'({w[BIT_PWR_HI], w[BIT_PWR_LO]});
  endfunction

  assign pwr = pwr_of(ctl);

  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      edge_cnt <= 5'h00;
    else if (cs_fall)
      edge_cnt <= 5'h00;
    else if (sclk_fall && active && edge_cnt < EDGES_WORD)
      edge_cnt <= edge_cnt + 5'h01;
  end

  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      active <= 1'b0;
    else if (cs_fall)
      active <= 1'b1;
    else if (cs_rise)
      active <= 1'b0;
  end

  // msb first capture of control bits
  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      shift_in <= 12'h000;
    else if (sclk_fall && active && edge_cnt < EDGES_CTL)
      shift_in <= {shift_in[CTL_W-2:0], din_s};
  end

  // channel for this conversion, sequence aware
  wire [1:0] pick_ch = seq_on ? seq_ch : {ctl[BIT_CH_HI], ctl[BIT_CH_LO]};

  // output word and falling edge shifting
  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      shift_out <= 16'h0000;
      conv_ch <= 2'h0;
    end
    else if (cs_fall)
    begin
      conv_ch <= pick_ch;
      shift_out <= {2'b00, pick_ch, sample_i};
    end
    else if (sclk_fall && active)
      shift_out <= {shift_out[WORD_W-2:0], 1'b0};
  end

  // no drive during wake from full shutdown
  // release on abort or 16th fall
  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      link.dout <= 1'b0;
      link.dout_oe <= 1'b0;
      drive_ok <= 1'b0;
    end
    else
    begin
      link.dout <= shift_out[WORD_W-1];
      if (cs_fall)
        drive_ok <= (pwr != PWR_FULL_OFF);
      else if (cs_rise || (sclk_fall && edge_cnt == EDGES_WORD - 5'h01))
        drive_ok <= 1'b0;
      link.dout_oe <= drive_ok & active & ~cs_rise;
    end
  end

  // update at cs rise after full word
  wire ctl_load = cs_rise && edge_cnt == EDGES_WORD && shift_in[BIT_WRITE];
  wire [1:0] new_seq = {shift_in[BIT_SEQ_HI], shift_in[BIT_SEQ_LO]};
  wire [1:0] seq_last = {ctl[BIT_CH_HI], ctl[BIT_CH_LO]};

  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      ctl <= CTL_RESET;
    else if (ctl_load)
      ctl <= shift_in;
  end

  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      seq_on <= 1'b0;
      seq_ch <= 2'h0;
    end
    else if (ctl_load && new_seq == 2'b11)
    begin
      seq_on <= 1'b1;
      seq_ch <= 2'h0;
    end
    else if (ctl_load && new_seq != 2'b10)
      seq_on <= 1'b0;
    else if (cs_rise && edge_cnt == EDGES_WORD && seq_on)
    begin
      if (conv_ch >= seq_last)
        seq_ch <= 2'h0;
      else
        seq_ch <= conv_ch + 2'h1;
    end
  end

  // power state; track on 14th fall
  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      powered_o <= 1'b1;
      tracking_o <= 1'b1;
    end
    else
    begin
      if (cs_fall)
        tracking_o <= 1'b0;
      else if (sclk_fall && edge_cnt == EDGE_TRACK - 5'h01)
        tracking_o <= 1'b1;
      else if (cs_rise && edge_cnt == EDGES_WORD && pwr_of(ctl_load ? shift_in : ctl) != PWR_NORMAL)
        tracking_o <= 1'b0;
      if (cs_fall && pwr == PWR_AUTO_OFF)
        powered_o <= 1'b1;
      else if (cs_rise && edge_cnt == EDGES_WORD)
        powered_o <= (pwr_of(ctl_load ? shift_in : ctl) == PWR_NORMAL);
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      mux_sel_o <= 2'h0;
      ctl_o <= CTL_RESET;
      busy_o <= 1'b0;
    end
    else
    begin
      mux_sel_o <= pick_ch;
      ctl_o <= ctl;
      busy_o <= active;
    end
  end
endmodule
`default_nettype wire

// *** src/adc_host_ctl.sv ***
/*
  host end: apb slave takes a control word, runs one 16-clock transfer, keeps the word read.
  assumes apb master on the same 25 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
module adc_host_ctl
  import adc_ctl_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic nrst_i,
  adc_link_if.host link,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o
);
  import adc_ctl_pkg::*;

  // ----------------------------------------
  // transfer engine
  // ----------------------------------------
  typedef enum {IDLE, QUIET, SHIFT, GAP} host_st_t;
  host_st_t st;
  logic [15:0] tx;
  logic [15:0] rx;
  logic [15:0] last_word;
  logic [4:0] bits;
  logic [2:0] half;
  logic [7:0] spacing;
  logic [7:0] quiet;
  logic start;
  logic done;
  logic dout_s;

  sync3 u_dout (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .async_i(link.dout), .sync_o(dout_s));

  wire acc = psel_i & penable_i;
  assign start = acc & pwrite_i & paddr_i == REG_CMD & st == IDLE;

  // cs spacing, quiet time, idle high
  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      st <= IDLE;
      link.cs_n <= 1'b1;
      link.sclk <= 1'b1;
      link.din <= 1'b0;
      tx <= 16'h0000;
      rx <= 16'h0000;
      last_word <= 16'h0000;
      bits <= 5'h00;
      half <= 3'h0;
      spacing <= 8'h00;
      quiet <= 8'h00;
      done <= 1'b0;
    end
    else
    begin
      if (spacing != 8'h00)
        spacing <= spacing - 8'h01;
      if (quiet != 8'h00)
        quiet <= quiet - 8'h01;
      case (st)
        IDLE:
        begin
          if (start)
          begin
            tx <= {pwdata_i[11:0], 4'h0};
            done <= 1'b0;
            st <= QUIET;
          end
        end
        QUIET:
        begin
          // the 5 us spacing also covers the wake time
          if (spacing == 8'h00 && quiet == 8'h00)
          begin
            link.cs_n <= 1'b0;
            link.din <= tx[15];
            tx <= {tx[14:0], 1'b0};
            spacing <= 8'(CONV_CYC);
            bits <= 5'h00;
            half <= 3'h0;
            st <= SHIFT;
          end
        end
        SHIFT:
        begin
          half <= half + 3'h1;
          if (half == 3'(SCLK_HALF_CYC - 1))
          begin
            half <= 3'h0;
            link.sclk <= ~link.sclk;
            if (link.sclk)
              bits <= bits + 5'h01;
            else
            begin
              // the device takes din on falls, so din moves on rises; the
              // return path is near ten cycles, two and a half half periods, so dout is taken on rises
              rx <= {rx[14:0], dout_s};
              link.din <= tx[15];
              tx <= {tx[14:0], 1'b0};
              if (bits == EDGES_WORD)
                st <= GAP;
            end
          end
        end
        GAP:
        begin
          link.cs_n <= 1'b1;
          last_word <= rx;
          done <= 1'b1;
          quiet <= 8'(QUIET_CYC);
          st <= IDLE;
        end
        default:
          st <= IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // apb slave, zero wait states
  // ----------------------------------------
  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      prdata_o <= 32'h00000000;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end
    else
    begin
      pready_o <= psel_i & ~penable_i;
      pslverr_o <= psel_i & ~penable_i & paddr_i != REG_CMD & paddr_i != REG_STATUS
        & paddr_i != REG_DATA;
      case (paddr_i)
        REG_STATUS: prdata_o <= {30'h00000000, done, st != IDLE};
        REG_DATA: prdata_o <= {16'h0000, last_word};
        default: prdata_o <= 32'h00000000;
      endcase
    end
  end
endmodule
`default_nettype wire

// *** bench/adc_link_sva.sv ***
/*
  assertions on the serial link between host end and converter end.
  assumes 25 MHz clock, 4-cycle serial half period, one 16-edge word per frame.
*/
`timescale 1ns/1ps
`default_nettype none
module adc_link_sva (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic din,
  input wire logic dout,
  input wire logic dout_oe
);
  logic cs_q;
  logic sclk_q;
  logic [7:0] gap;
  logic [4:0] falls;
  default clocking @(posedge core_clk_i);
  endclocking
  default disable iff (!nrst_i);
  // ----------------------------------------
  // helper counters
  // ----------------------------------------
  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      cs_q <= 1'b1;
      sclk_q <= 1'b1;
    end
    else
    begin
      cs_q <= cs_n;
      sclk_q <= sclk;
    end
  end
  // saturates so a long idle never wraps into a false short gap
  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      gap <= 8'hFF;
    else if (cs_q && !cs_n)
      gap <= 8'h00;
    else if (gap != 8'hFF)
      gap <= gap + 8'h01;
  end
  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      falls <= 5'h00;
    else if (cs_n)
      falls <= 5'h00;
    else if (sclk_q && !sclk)
      falls <= falls + 5'h01;
  end
  // ----------------------------------------
  // link checks
  // ----------------------------------------
  a_frame_sixteen: assert property ($rose(cs_n) |-> falls == 5'h10)
    else $error("frame did not hold sixteen falls");
  a_frame_spacing: assert property ($fell(cs_n) |-> gap >= 8'd124)
    else $error("frames start too close together");
  a_quiet_gap: assert property ($rose(cs_n) |-> cs_n[*2])
    else $error("select dropped inside quiet time");
  a_sclk_half: assert property ($fell(sclk) |-> !sclk[*4] ##1 sclk)
    else $error("serial clock low phase not four cycles");
  a_sclk_idle: assert property (cs_n[*8] |-> sclk)
    else $error("serial clock not idle high");
  a_lead_zero: assert property ($rose(dout_oe) |-> !dout[*8])
    else $error("word does not open with zeros");
  a_oe_release: assert property ($rose(cs_n) |-> ##[0:6] !dout_oe)
    else $error("data output not released after frame");
  a_oe_idle: assert property (cs_n[*8] |-> !dout_oe)
    else $error("data output driven while idle");
endmodule
`default_nettype wire

// *** bench/adc_sequencer_power_control_tb.sv ***
/*
  testbench: host end and converter end joined by the link, driven over apb.
  assumes the host paces frames itself and the design package constants.
*/
`timescale 1ns/1ps
`default_nettype none
module adc_sequencer_power_control_tb;
  import adc_ctl_pkg::*;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic pready;
  logic pslverr;
  logic err;
  logic [RES_W-1:0] smp = 12'h000;
  logic [RES_W-1:0] cur;
  logic [1:0] mux_sel;
  logic tracking;
  logic powered;
  logic dev_busy;
  logic [CTL_W-1:0] ctl;
  int fails = 0;
  int checked = 0;
  int oe_cnt = 0;
  int on_cnt = 0;
  int off_cnt = 0;
  adc_link_if link ();
  adc_dev_ctl i_adc_dev_ctl (.core_clk_i(core_clk), .nrst_i(nrst), .link(link),
    .sample_i(smp), .mux_sel_o(mux_sel), .tracking_o(tracking), .powered_o(powered),
    .ctl_o(ctl), .busy_o(dev_busy));
  adc_host_ctl i_adc_host_ctl (.core_clk_i(core_clk), .nrst_i(nrst), .link(link),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr));
  adc_link_sva i_adc_link_sva (.core_clk_i(core_clk), .nrst_i(nrst), .cs_n(link.cs_n),
    .sclk(link.sclk), .din(link.din), .dout(link.dout), .dout_oe(link.dout_oe));
  always #20 core_clk = ~core_clk;
  always @(posedge core_clk)
  begin
    oe_cnt += (link.dout_oe === 1'b1);
    on_cnt += (powered === 1'b1);
    off_cnt += (powered === 1'b0);
  end
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp)
    begin
      fails++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1 && n < 50)
    begin
      n++;
      @(posedge core_clk);
    end
    if (pready !== 1'b1)
    begin
      fails++;
      $display("unexpected at %0t: apb answer never came", $time);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask
  function automatic logic [11:0] cw(logic wr, logic [1:0] sq, logic [1:0] ch, logic [1:0] pm);
    logic [11:0] w;
    w = 12'h000;
    w[BIT_WRITE] = wr;
    w[BIT_SEQ_HI] = sq[1];
    w[BIT_SEQ_LO] = sq[0];
    w[BIT_CH_HI:BIT_CH_LO] = ch;
    w[BIT_PWR_HI:BIT_PWR_LO] = pm;
    return w;
  endfunction
  // waits for the frame to end on both sides, then checks the word if ch >= 0
  task automatic fin(input int ch);
    int n;
    n = 0;
    do
    begin
      apb(1'b0, REG_STATUS, 32'h0);
      n++;
    end
    while (rd[0] !== 1'b0 && n < 300);
    while (dev_busy !== 1'b0 && n < 600)
    begin
      n++;
      @(posedge core_clk);
    end
    if (n >= 300)
    begin
      fails++;
      $display("unexpected at %0t: frame never ended", $time);
    end
    repeat (2) @(posedge core_clk);
    if (ch >= 0)
    begin
      apb(1'b0, REG_DATA, 32'h0);
      chk({16'h0, rd[15:0]}, {16'h0, 2'b00, ch[1:0], cur}, "word");
    end
  endtask
  task automatic xfer(input logic [11:0] w, input int ch);
    cur = smp + 12'h123;
    smp <= cur;
    apb(1'b1, REG_CMD, {20'h0, w});
    fin(ch);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic s_select;
    int i;
    int o;
    o = off_cnt;
    for (i = 0; i < 4; i++)
    begin
      xfer(cw(1'b1, 2'b00, i[1:0], 2'b11), (i + 3) % 4);
      chk({20'h0, ctl}, {20'h0, cw(1'b1, 2'b00, i[1:0], 2'b11)}, "ctl");
      chk({30'h0, mux_sel}, i, "mux");
      chk({31'h0, tracking}, 32'h1, "track");
    end
    xfer(cw(1'b0, 2'b11, 2'b00, 2'b10), 3);
    chk({20'h0, ctl}, {20'h0, cw(1'b1, 2'b00, 2'b11, 2'b11)}, "held ctl");
    chk(off_cnt - o, 0, "normal power");
  endtask
  task automatic s_seq;
    int i;
    xfer(cw(1'b1, 2'b11, 2'b10, 2'b11), 3);
    for (i = 0; i < 4; i++)
      xfer(12'h000, i % 3);
    xfer(cw(1'b1, 2'b10, 2'b10, 2'b11), 1);
    xfer(12'h000, 2);
    xfer(cw(1'b1, 2'b00, 2'b01, 2'b11), 0);
    xfer(12'h000, 1);
    xfer(12'h000, 1);
  endtask
  task automatic s_power;
    int o;
    xfer(cw(1'b1, 2'b00, 2'b01, 2'b10), -1);
    chk({31'h0, powered}, 32'h0, "full off");
    xfer(12'h000, -1);
    chk({31'h0, powered}, 32'h0, "stays off");
    chk({20'h0, ctl}, {20'h0, cw(1'b1, 2'b00, 2'b01, 2'b10)}, "kept ctl");
    o = oe_cnt;
    xfer(cw(1'b1, 2'b00, 2'b01, 2'b11), -1);
    chk(oe_cnt - o, 0, "wake drive");
    chk({31'h0, powered}, 32'h1, "woken");
    xfer(cw(1'b1, 2'b00, 2'b01, 2'b01), 1);
    chk({31'h0, powered}, 32'h0, "auto off");
    chk({31'h0, tracking}, 32'h0, "auto hold");
    o = on_cnt;
    xfer(12'h000, 1);
    chk({31'h0, on_cnt > o}, 32'h1, "auto wake");
    chk({31'h0, powered}, 32'h0, "auto off again");
  endtask
  task automatic s_refuse;
    apb(1'b1, REG_CMD, {20'h0, cw(1'b1, 2'b00, 2'b10, 2'b11)});
    apb(1'b1, REG_CMD, {20'h0, cw(1'b1, 2'b00, 2'b01, 2'b11)});
    fin(-1);
    chk({30'h0, mux_sel}, 32'h2, "busy write refused");
    apb(1'b0, 8'h0C, 32'h0);
    chk({31'h0, err}, 32'h1, "unmapped");
  endtask
  task automatic wrap_up;
    if (fails == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    repeat (10) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    s_select;
    s_seq;
    s_power;
    s_refuse;
    wrap_up;
  end
  // about twenty frames of some hundred and fifty cycles each fit well inside this
  initial
  begin
    repeat (60000) @(posedge core_clk);
    fails++;
    wrap_up;
  end
endmodule
`default_nettype wire
